// *** design/uepc_hs_pick.sv ***
`timescale 1ns/1ps
`default_nettype none
module uepc_hs_pick
  import uepc_pkg::*;
(
  input wire uepc_in_ep_s s,
  input wire logic frame_odd,
  input wire logic global_in_nak,
  input wire logic global_out_nak,
  input wire logic tx_ready,
  output uepc_hs_e code
);
  always_comb
  begin
    code = UEPC_HS_NONE;
    if (!s.active)
      code = UEPC_HS_NONE;
    else if (s.kind == UEPC_KIND_ISO)
    begin
      // Iso has no handshake, stall does not apply
      if (s.parity != frame_odd)
        code = UEPC_HS_NONE;
      else if (s.nak || global_in_nak)
        code = UEPC_HS_ZLP;
      else if (s.go && tx_ready)
        code = UEPC_HS_DATA;
      else
        code = UEPC_HS_ZLP;
    end
    else if (s.stall)
      code = UEPC_HS_STALL;
    else if (s.nak || global_in_nak || global_out_nak)
      code = UEPC_HS_NAK;
    else if (s.go && tx_ready)
      code = UEPC_HS_DATA;
    else
      code = UEPC_HS_NAK;
  end
endmodule
`default_nettype wire

// *** design/uepc_in_ep.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uepc_map.svh"
module uepc_in_ep
  import uepc_pkg::*;
#(
  parameter bit IS_EP0 = 1'b0
)
(
  input wire logic clk,
  input wire logic reset,
  input wire uepc_wr_s wr,
  input wire logic setup_hit,
  input wire logic bus_reset,
  input wire logic host_ack,
  input wire logic xfer_done,
  input wire logic disable_done,
  output uepc_in_ep_s state,
  output logic [31:0] rd_word
);
  uepc_in_ep_s s_reg;
  uepc_in_ep_s s_next;
  logic [31:0] d;
  logic [31:0] m;

  always_comb
  begin
    s_next = s_reg;
    m = wr.mask;
    d = wr.data & wr.mask;
    s_next.xfer_evt = s_reg.xfer_pend;
    s_next.dis_evt = s_reg.dis_pend;
    s_next.xfer_pend = 1'b0;
    s_next.dis_pend = 1'b0;
    // Bit drops one edge before the event is raised
    if (xfer_done)
    begin
      s_next.go = 1'b0;
      s_next.xfer_pend = 1'b1;
    end
    if (disable_done)
    begin
      s_next.go = 1'b0;
      s_next.stop = 1'b0;
      s_next.dis_pend = 1'b1;
    end
    if (host_ack && s_reg.kind != UEPC_KIND_ISO)
      s_next.toggle = ~s_reg.toggle;
    if (setup_hit && s_reg.kind == UEPC_KIND_CTRL)
      s_next.stall = 1'b0;
    if (bus_reset && !IS_EP0)
      s_next.active = 1'b0;
    if (wr.en)
    begin
      // Software writes after hardware events, so a set is never lost
      if (d[`UEPC_B_GO])
        s_next.go = 1'b1;
      if (d[`UEPC_B_STOP] && s_reg.go)
        s_next.stop = 1'b1;
      if (d[`UEPC_B_ODD] && s_reg.kind == UEPC_KIND_ISO)
        s_next.parity = 1'b1;
      if (d[`UEPC_B_EVEN_D0])
      begin
        if (s_reg.kind == UEPC_KIND_ISO)
          s_next.parity = 1'b0;
        else if (s_reg.kind != UEPC_KIND_CTRL)
          s_next.toggle = 1'b0;
      end
      if (d[`UEPC_B_NCLR])
        s_next.nak = 1'b0;
      if (d[`UEPC_B_NSET])
        s_next.nak = 1'b1;
      s_next.txf = (s_reg.txf & ~m[`UEPC_TXF_HI:`UEPC_TXF_LO]) |
        d[`UEPC_TXF_HI:`UEPC_TXF_LO];
      if (s_reg.kind == UEPC_KIND_CTRL)
        s_next.stall = s_next.stall | d[`UEPC_B_STALL];
      else
        s_next.stall = (s_reg.stall & ~m[`UEPC_B_STALL]) | d[`UEPC_B_STALL];
      s_next.kind = uepc_kind_e'((s_reg.kind & ~m[`UEPC_KIND_HI:`UEPC_KIND_LO]) |
        d[`UEPC_KIND_HI:`UEPC_KIND_LO]);
      s_next.active = (s_next.active & ~m[`UEPC_B_ACTIVE]) | d[`UEPC_B_ACTIVE];
      s_next.mps = (s_reg.mps & ~m[`UEPC_MPS_HI:`UEPC_MPS_LO]) |
        d[`UEPC_MPS_HI:`UEPC_MPS_LO];
    end
    if (reset)
      s_next = '0;
  end

  always_ff @(posedge clk)
  begin
    s_reg <= s_next;
  end

  assign state = s_reg;
  // Strobes read as zero
  assign rd_word = {s_reg.go, s_reg.stop, 4'h0, s_reg.txf, s_reg.stall, 1'b0,
    s_reg.kind, s_reg.nak, (s_reg.kind == UEPC_KIND_ISO) ? s_reg.parity : s_reg.toggle,
    s_reg.active, 4'h0, s_reg.mps};
endmodule
`default_nettype wire

// *** design/uepc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "uepc_map.svh"
module uepc_top
  import uepc_pkg::*;
#(
  parameter int N_IN = 8,
  parameter int ADDR_W = 12
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic USB_BUS_RESET,
  input wire logic TOKEN_VALID,
  input wire uepc_tok_e TOKEN_PID,
  input wire logic [3:0] TOKEN_EP,
  input wire logic FRAME_ODD,
  input wire logic GLOBAL_IN_NAK,
  input wire logic GLOBAL_OUT_NAK,
  input wire logic RX_ROOM,
  input wire logic [N_IN-1:0] TX_READY,
  input wire logic [N_IN-1:0] IN_HOST_ACK,
  input wire logic [N_IN-1:0] IN_XFER_DONE,
  input wire logic [N_IN-1:0] IN_DISABLE_DONE,
  input wire logic OUT0_XFER_DONE,
  input wire logic OUT0_SETUP_DONE,
  output logic HS_VALID,
  output uepc_hs_e HS_CODE,
  output logic HS_DATA_PID,
  output logic [N_IN-1:0] IN_XFER_DONE_EVT,
  output logic [N_IN-1:0] IN_DISABLED_EVT,
  output logic [N_IN-1:0] IN_GO,
  output logic [N_IN-1:0] IN_STOP_REQ,
  output logic [N_IN*4-1:0] TX_FIFO_SEL,
  output logic OUT0_XFER_DONE_EVT,
  output logic OUT0_SETUP_DONE_EVT,
  output logic OUT0_GO,
  output logic OUT0_SNOOP
);
  uepc_top_s s_reg;
  uepc_top_s s_next;
  uepc_wr_s in_wr [N_IN];
  uepc_in_ep_s in_st [N_IN];
  logic [31:0] in_rd [N_IN];
  uepc_hs_e in_code [N_IN];
  logic [N_IN-1:0] setup_hit;
  uepc_dec_s wdec;
  uepc_dec_s rdec;
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic [31:0] o0_rd;
  logic [31:0] rd_word;
  logic rd_hit;
  logic setup0;
  uepc_hs_e o0_code;
  uepc_hs_e in_sel_code;
  logic in_sel_pid;

  function automatic uepc_dec_s decode(input logic [ADDR_W-1:0] a);
    uepc_dec_s r;
    logic [ADDR_W-1:0] diff;
    diff = a - ADDR_W'(`UEPC_IN_BASE);
    // Only the control word of each stride lives here; the rest is decode error
    r.in_hit = (a >= ADDR_W'(`UEPC_IN_BASE)) &&
      ((diff >> `UEPC_STRIDE_SH) < ADDR_W'(N_IN)) &&
      (diff[`UEPC_STRIDE_SH-1:0] == '0);
    r.idx = 4'(diff >> `UEPC_STRIDE_SH);
    r.out0_hit = (a == ADDR_W'(`UEPC_OUT0_OFS));
    return r;
  endfunction

  always_comb
  begin
    wdec = decode(s_reg.aw_addr[ADDR_W-1:0]);
    rdec = decode(S_AXI_ARADDR);
    wr_go = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
    for (int b = 0; b < 4; b++)
      wmask[b*8 +: 8] = {8{s_reg.w_strb[b]}};
    wd = s_reg.w_data & wmask;
    setup0 = TOKEN_VALID && TOKEN_PID == UEPC_TOK_SETUP && TOKEN_EP == 4'h0;
    for (int i = 0; i < N_IN; i++)
    begin
      in_wr[i].en = wr_go && wdec.in_hit && wdec.idx == 4'(i);
      in_wr[i].data = s_reg.w_data;
      in_wr[i].mask = wmask;
      setup_hit[i] = TOKEN_VALID && TOKEN_PID == UEPC_TOK_SETUP && TOKEN_EP == 4'(i);
    end
  end

  always_comb
  begin
    o0_rd = `UEPC_OUT0_RESET;
    o0_rd[`UEPC_B_GO] = s_reg.o0_go;
    o0_rd[`UEPC_B_STALL] = s_reg.o0_stall;
    o0_rd[`UEPC_B_SNOOP] = s_reg.o0_snoop;
    o0_rd[`UEPC_B_NAKACT] = s_reg.o0_nak;
    o0_rd[`UEPC_MPS0_HI:`UEPC_MPS_LO] = in_st[0].mps[`UEPC_MPS0_HI:`UEPC_MPS_LO];
    rd_word = '0;
    rd_hit = 1'b0;
    for (int i = 0; i < N_IN; i++)
    begin
      if (rdec.in_hit && rdec.idx == 4'(i))
      begin
        rd_word = in_rd[i];
        rd_hit = 1'b1;
      end
    end
    if (rdec.out0_hit)
    begin
      rd_word = o0_rd;
      rd_hit = 1'b1;
    end
  end

  // IN answer of the addressed endpoint; unknown endpoints stay silent
  always_comb
  begin
    in_sel_code = UEPC_HS_NONE;
    in_sel_pid = 1'b0;
    for (int i = 0; i < N_IN; i++)
    begin
      if (TOKEN_EP == 4'(i))
      begin
        in_sel_code = in_code[i];
        in_sel_pid = in_st[i].toggle;
      end
    end
  end

  // OUT answer of endpoint 0; stall outranks every NAK source
  always_comb
  begin
    if (s_reg.o0_stall)
      o0_code = UEPC_HS_STALL;
    else if (s_reg.o0_nak || GLOBAL_OUT_NAK)
      o0_code = UEPC_HS_NAK;
    else if (s_reg.o0_go && RX_ROOM)
      o0_code = UEPC_HS_ACK;
    else
      o0_code = UEPC_HS_NAK;
  end

  always_comb
  begin
    s_next = s_reg;
    // Write address and data are taken in either order
    if (S_AXI_AWVALID && s_reg.awready)
    begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = 12'(S_AXI_AWADDR);
    end
    if (S_AXI_WVALID && s_reg.wready)
    begin
      s_next.w_have = 1'b1;
      s_next.w_data = S_AXI_WDATA;
      s_next.w_strb = S_AXI_WSTRB;
    end
    if (s_reg.bvalid && S_AXI_BREADY)
      s_next.bvalid = 1'b0;
    if (wr_go)
    begin
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = (wdec.in_hit || wdec.out0_hit) ? `UEPC_RESP_OKAY : `UEPC_RESP_DECERR;
    end
    s_next.awready = !s_next.aw_have;
    s_next.wready = !s_next.w_have;
    if (S_AXI_ARVALID && s_reg.arready)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_word;
      s_next.rresp = rd_hit ? `UEPC_RESP_OKAY : `UEPC_RESP_DECERR;
    end
    else if (s_reg.rvalid && S_AXI_RREADY)
      s_next.rvalid = 1'b0;
    s_next.arready = !s_next.rvalid;

    // Endpoint 0 OUT: events are raised one edge after the go bit drops
    s_next.o0_xfer_evt = s_reg.o0_xfer_pend;
    s_next.o0_setup_evt = s_reg.o0_setup_pend;
    s_next.o0_xfer_pend = 1'b0;
    s_next.o0_setup_pend = 1'b0;
    if (OUT0_XFER_DONE)
    begin
      s_next.o0_go = 1'b0;
      s_next.o0_xfer_pend = 1'b1;
    end
    if (OUT0_SETUP_DONE)
    begin
      s_next.o0_go = 1'b0;
      s_next.o0_setup_pend = 1'b1;
    end
    if (setup0)
      s_next.o0_stall = 1'b0;
    if (wr_go && wdec.out0_hit)
    begin
      // Stop bit has no storage here: endpoint 0 OUT cannot be disabled
      if (wd[`UEPC_B_GO])
        s_next.o0_go = 1'b1;
      if (wd[`UEPC_B_NCLR])
        s_next.o0_nak = 1'b0;
      if (wd[`UEPC_B_NSET])
        s_next.o0_nak = 1'b1;
      if (wd[`UEPC_B_STALL])
        s_next.o0_stall = 1'b1;
      s_next.o0_snoop = (s_reg.o0_snoop & ~wmask[`UEPC_B_SNOOP]) | wd[`UEPC_B_SNOOP];
    end
    // Hardware NAK set after software clear, so the set wins
    if (OUT0_XFER_DONE || setup0)
      s_next.o0_nak = 1'b1;

    // Handshake answer for the current token, registered
    s_next.hs_code = UEPC_HS_NONE;
    s_next.hs_pid = 1'b0;
    if (TOKEN_VALID)
    begin
      case (TOKEN_PID)
        UEPC_TOK_SETUP:
        begin
          if (TOKEN_EP == 4'h0)
            s_next.hs_code = UEPC_HS_ACK;
        end
        UEPC_TOK_OUT:
        begin
          if (TOKEN_EP == 4'h0)
            s_next.hs_code = o0_code;
        end
        UEPC_TOK_IN:
        begin
          s_next.hs_code = in_sel_code;
          s_next.hs_pid = in_sel_pid;
        end
        default:
          s_next.hs_code = UEPC_HS_NONE;
      endcase
    end
    s_next.hs_valid = (s_next.hs_code != UEPC_HS_NONE);
    // Reset last, so it beats every update of the same edge
    if (RESET)
      s_next = '0;
  end

  always_ff @(posedge CLK)
  begin
    s_reg <= s_next;
  end

  for (genvar g = 0; g < N_IN; g++)
  begin : g_ep
    // Endpoint 0 keeps its active bit through bus reset
    uepc_in_ep #(
      .IS_EP0(g == 0)
    ) u_ep (
      .clk(CLK),
      .reset(RESET),
      .wr(in_wr[g]),
      .setup_hit(setup_hit[g]),
      .bus_reset(USB_BUS_RESET),
      .host_ack(IN_HOST_ACK[g]),
      .xfer_done(IN_XFER_DONE[g]),
      .disable_done(IN_DISABLE_DONE[g]),
      .state(in_st[g]),
      .rd_word(in_rd[g])
    );
    // Control IN endpoints see no global OUT NAK here
    uepc_hs_pick u_pick (
      .s(in_st[g]),
      .frame_odd(FRAME_ODD),
      .global_in_nak(GLOBAL_IN_NAK),
      .global_out_nak(1'b0),
      .tx_ready(TX_READY[g]),
      .code(in_code[g])
    );
    assign IN_XFER_DONE_EVT[g] = in_st[g].xfer_evt;
    assign IN_DISABLED_EVT[g] = in_st[g].dis_evt;
    assign IN_GO[g] = in_st[g].go;
    assign IN_STOP_REQ[g] = in_st[g].stop;
    assign TX_FIFO_SEL[g*4 +: 4] = in_st[g].txf;
  end

  assign S_AXI_AWREADY = s_reg.awready;
  assign S_AXI_WREADY = s_reg.wready;
  assign S_AXI_BRESP = s_reg.bresp;
  assign S_AXI_BVALID = s_reg.bvalid;
  assign S_AXI_ARREADY = s_reg.arready;
  assign S_AXI_RDATA = s_reg.rdata;
  assign S_AXI_RRESP = s_reg.rresp;
  assign S_AXI_RVALID = s_reg.rvalid;
  assign HS_VALID = s_reg.hs_valid;
  assign HS_CODE = s_reg.hs_code;
  assign HS_DATA_PID = s_reg.hs_pid;
  assign OUT0_XFER_DONE_EVT = s_reg.o0_xfer_evt;
  assign OUT0_SETUP_DONE_EVT = s_reg.o0_setup_evt;
  assign OUT0_GO = s_reg.o0_go;
  assign OUT0_SNOOP = s_reg.o0_snoop;
endmodule
`default_nettype wire

// *** include/uepc_map.svh ***
`ifndef UEPC_MAP_SVH
`define UEPC_MAP_SVH
`define UEPC_IN_BASE 12'h900
`define UEPC_STRIDE_SH 5
`define UEPC_OUT0_OFS 12'hb00
`define UEPC_OUT0_RESET 32'h00008000
`define UEPC_B_GO 31
`define UEPC_B_STOP 30
`define UEPC_B_ODD 29
`define UEPC_B_EVEN_D0 28
`define UEPC_B_NSET 27
`define UEPC_B_NCLR 26
`define UEPC_TXF_HI 25
`define UEPC_TXF_LO 22
`define UEPC_B_STALL 21
`define UEPC_B_SNOOP 20
`define UEPC_KIND_HI 19
`define UEPC_KIND_LO 18
`define UEPC_B_NAKACT 17
`define UEPC_B_PAR 16
`define UEPC_B_ACTIVE 15
`define UEPC_MPS_HI 10
`define UEPC_MPS0_HI 1
`define UEPC_MPS_LO 0
`define UEPC_RESP_OKAY 2'h0
`define UEPC_RESP_DECERR 2'h3
`endif

// *** include/uepc_pkg.sv ***
package uepc_pkg;
  typedef enum logic [1:0] {
    UEPC_KIND_CTRL = 2'h0,
    UEPC_KIND_ISO = 2'h1,
    UEPC_KIND_BULK = 2'h2,
    UEPC_KIND_INTR = 2'h3
  } uepc_kind_e;
  typedef enum logic [2:0] {
    UEPC_HS_NONE = 3'h0,
    UEPC_HS_ACK = 3'h1,
    UEPC_HS_NAK = 3'h2,
    UEPC_HS_STALL = 3'h3,
    UEPC_HS_DATA = 3'h4,
    UEPC_HS_ZLP = 3'h5
  } uepc_hs_e;
  typedef enum logic [1:0] {
    UEPC_TOK_OUT = 2'h0,
    UEPC_TOK_IN = 2'h1,
    UEPC_TOK_SETUP = 2'h2
  } uepc_tok_e;
  typedef struct packed {
    logic en;
    logic [31:0] data;
    logic [31:0] mask;
  } uepc_wr_s;
  typedef struct packed {
    logic in_hit;
    logic [3:0] idx;
    logic out0_hit;
  } uepc_dec_s;
  typedef struct packed {
    logic go;
    logic stop;
    logic nak;
    logic stall;
    uepc_kind_e kind;
    logic [3:0] txf;
    logic parity;
    logic toggle;
    logic active;
    logic [10:0] mps;
    logic xfer_pend;
    logic dis_pend;
    logic xfer_evt;
    logic dis_evt;
  } uepc_in_ep_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_have;
    logic [11:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic o0_go;
    logic o0_nak;
    logic o0_stall;
    logic o0_snoop;
    logic o0_xfer_pend;
    logic o0_setup_pend;
    logic o0_xfer_evt;
    logic o0_setup_evt;
    logic hs_valid;
    uepc_hs_e hs_code;
    logic hs_pid;
  } uepc_top_s;
endpackage

// *** tb/test_usb_device_endpoint_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_usb_device_endpoint_control
  import uepc_pkg::*;
;
  localparam int NI = 8;
  localparam logic [31:0] GO = 32'h80000000, ACT = 32'h00008000, NAK = 32'h00020000;
  localparam logic [4:0] NONE = 5'h1f;
  logic clk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, b1, b2;
  logic bus_rst = 1'b0, g_in = 1'b0, f_odd = 1'b0, o_xd = 1'b0, o_sd = 1'b0, req = 1'b0;
  logic slow = 1'b0, g_out = 1'b0, rx_room = 1'b1;
  logic [NI-1:0] tx_rdy = '1, x_done = '0, d_done = '0, xev, dev, in_go, in_stop, h_ack;
  uepc_tok_e req_pid = UEPC_TOK_IN, tok_pid;
  logic [3:0] req_ep = '0, tok_ep;
  logic awready, wready, bvalid, arready, rvalid, hs_valid, hs_pid, o_xev, o_sev, o0_go;
  logic o0_snoop, tok_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [NI*4-1:0] txf_sel;
  uepc_hs_e hs_code;
  int n_errors = 0, n_tests = 0, cyc = 0;
  integer seed = 32'hcb5b;
  logic [33:0] rq[$], e;
  logic [4:0] hq[$], h;
  logic [1:0] bq[$];
  logic [17:0] eq[$];
  uepc_top #(.N_IN(NI)) dut (.CLK(clk), .RESET(reset), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
    .USB_BUS_RESET(bus_rst), .TOKEN_VALID(tok_valid), .TOKEN_PID(tok_pid),
    .TOKEN_EP(tok_ep), .FRAME_ODD(f_odd), .GLOBAL_IN_NAK(g_in), .GLOBAL_OUT_NAK(g_out),
    .RX_ROOM(rx_room), .TX_READY(tx_rdy), .IN_HOST_ACK(h_ack), .IN_XFER_DONE(x_done),
    .IN_DISABLE_DONE(d_done), .OUT0_XFER_DONE(o_xd), .OUT0_SETUP_DONE(o_sd),
    .HS_VALID(hs_valid), .HS_CODE(hs_code), .HS_DATA_PID(hs_pid),
    .IN_XFER_DONE_EVT(xev), .IN_DISABLED_EVT(dev), .IN_GO(in_go), .IN_STOP_REQ(in_stop),
    .TX_FIFO_SEL(txf_sel), .OUT0_XFER_DONE_EVT(o_xev), .OUT0_SETUP_DONE_EVT(o_sev),
    .OUT0_GO(o0_go), .OUT0_SNOOP(o0_snoop));
  uepc_host host (.clk(clk), .req(req), .req_pid(req_pid), .req_ep(req_ep), .slow(slow),
    .hs_valid(hs_valid), .hs_code(hs_code), .tok_valid(tok_valid), .tok_pid(tok_pid),
    .tok_ep(tok_ep), .host_ack(h_ack));
  always #50 clk = ~clk;
  task check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    bit ao;
    bit wo;
    ao = 0;
    wo = 0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ao && wo))
    begin
      @(posedge clk);
      if (awvalid && awready)
      begin
        ao = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wo = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
  endtask
  task rd(input logic [11:0] a, input logic [33:0] x);
    rq.push_back(x);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
  endtask
  task tok(input uepc_tok_e p, input logic [3:0] ep, input logic [4:0] x);
    if (x != NONE)
      hq.push_back(x);
    req <= 1'b1;
    req_pid <= p;
    req_ep <= ep;
    @(posedge clk);
    req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task pulse(input logic [17:0] v);
    eq.push_back(v);
    {o_sd, o_xd, d_done, x_done} <= v;
    @(posedge clk);
    {o_sd, o_xd, d_done, x_done} <= '0;
    repeat (4) @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    if (!reset)
    begin
      if (rvalid)
      begin
        e = rq.size() ? rq.pop_front() : 'x;
        check("read", {rresp, rdata}, e);
      end
      if (bvalid)
        check("bresp", bresp, bq.size() ? bq.pop_front() : 'x);
      if (hs_valid)
      begin
        h = hq.size() ? hq.pop_front() : 'x;
        check("handshake", {hs_code, h[4] ? hs_pid : 1'b0}, h[3:0]);
      end
      if (|{o_sev, o_xev, dev, xev})
        check("event", {o_sev, o_xev, dev, xev}, eq.size() ? eq.pop_front() : 'x);
      cyc++;
      // Whole run needs a few hundred cycles; anything past this is a hang
      if (cyc > 20000)
      begin
        n_errors++;
        final_report;
      end
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    b1 = 32'h00c88000 | (32'($random(seed)) & 32'h7ff);
    b2 = 32'h014483ff;
    rd(12'h900, 34'h0);
    rd(12'hb00, ACT);
    rd(12'h904, {2'h3, 32'h0});
    wr(12'h904, '1, 2'h3);
    wr(12'h900, ACT | 32'h3);
    rd(12'hb00, ACT | 32'h3);
    wr(12'h920, b1 | 32'h08000000);
    rd(12'h920, b1 | NAK);
    wr(12'h920, b1 | GO | 32'h10000000);
    tok(UEPC_TOK_IN, 4'h1, {1'b1, UEPC_HS_NAK, 1'b0});
    wr(12'h920, b1 | 32'h04000000);
    tok(UEPC_TOK_IN, 4'h1, {1'b1, UEPC_HS_DATA, 1'b0});
    slow <= 1'b1;
    tok(UEPC_TOK_IN, 4'h1, {1'b1, UEPC_HS_DATA, 1'b1});
    rd(12'h920, b1 | GO);
    tx_rdy <= '0;
    tok(UEPC_TOK_IN, 4'h1, {1'b1, UEPC_HS_NAK, 1'b0});
    tx_rdy <= '1;
    g_in <= 1'b1;
    tok(UEPC_TOK_IN, 4'h1, {1'b1, UEPC_HS_NAK, 1'b0});
    g_in <= 1'b0;
    wr(12'h920, b1 | 32'h08200000);
    tok(UEPC_TOK_IN, 4'h1, {1'b1, UEPC_HS_STALL, 1'b0});
    tok(UEPC_TOK_SETUP, 4'h0, {1'b0, UEPC_HS_ACK, 1'b0});
    wr(12'h920, b1 | 32'h00200000);
    rd(12'h920, b1 | GO | NAK | 32'h00200000);
    wr(12'h920, b1 | 32'h04000000);
    pulse(18'h00002);
    rd(12'h920, b1);
    wr(12'h920, b1 | 32'h40000000);
    rd(12'h920, b1);
    wr(12'h920, b1 | GO);
    wr(12'h920, b1 | 32'h40000000);
    rd(12'h920, b1 | GO | 32'h40000000);
    pulse(18'h00200);
    rd(12'h920, b1);
    bus_rst <= 1'b1;
    @(posedge clk);
    bus_rst <= 1'b0;
    rd(12'h920, b1 & ~ACT);
    rd(12'h900, ACT | 32'h3);
    tok(UEPC_TOK_IN, 4'h1, NONE);
    wr(12'h940, b2);
    wr(12'h940, b2 | GO | 32'h24000000);
    rd(12'h940, b2 | GO | 32'h00010000);
    check("fifo select", txf_sel, {20'h0, b2[25:22], b1[25:22], 4'h0});
    f_odd <= 1'b1;
    tok(UEPC_TOK_IN, 4'h2, {1'b0, UEPC_HS_DATA, 1'b0});
    f_odd <= 1'b0;
    tok(UEPC_TOK_IN, 4'h2, NONE);
    f_odd <= 1'b1;
    wr(12'h940, b2 | 32'h08000000);
    tok(UEPC_TOK_IN, 4'h2, {1'b0, UEPC_HS_ZLP, 1'b0});
    wr(12'h940, b2 | 32'h10000000);
    rd(12'h940, b2 | GO | NAK);
    wr(12'hb00, 32'hc4300000);
    rd(12'hb00, 32'h80308003);
    check("out0 levels", {o0_snoop, o0_go}, 2'b11);
    g_out <= 1'b1;
    tok(UEPC_TOK_OUT, 4'h0, {1'b0, UEPC_HS_STALL, 1'b0});
    tok(UEPC_TOK_SETUP, 4'h0, {1'b0, UEPC_HS_ACK, 1'b0});
    g_out <= 1'b0;
    rd(12'hb00, 32'h80128003);
    wr(12'hb00, 32'h04100000);
    tok(UEPC_TOK_OUT, 4'h0, {1'b0, UEPC_HS_ACK, 1'b0});
    rx_room <= 1'b0;
    tok(UEPC_TOK_OUT, 4'h0, {1'b0, UEPC_HS_NAK, 1'b0});
    rx_room <= 1'b1;
    g_out <= 1'b1;
    tok(UEPC_TOK_OUT, 4'h0, {1'b0, UEPC_HS_NAK, 1'b0});
    g_out <= 1'b0;
    wr(12'hb00, 32'h08100000);
    tok(UEPC_TOK_OUT, 4'h0, {1'b0, UEPC_HS_NAK, 1'b0});
    pulse(18'h10000);
    rd(12'hb00, 32'h00128003);
    pulse(18'h20000);
    final_report;
  end
endmodule
bind uepc_top uepc_checker #(.N_IN(N_IN)) chk (.*);
`default_nettype wire

// *** tb/uepc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module uepc_checker
  import uepc_pkg::*;
#(
  parameter int N_IN = 8
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic TOKEN_VALID,
  input wire uepc_tok_e TOKEN_PID,
  input wire logic [3:0] TOKEN_EP,
  input wire logic GLOBAL_IN_NAK,
  input wire logic HS_VALID,
  input wire uepc_hs_e HS_CODE,
  input wire logic [N_IN-1:0] IN_XFER_DONE,
  input wire logic [N_IN-1:0] IN_XFER_DONE_EVT,
  input wire logic [N_IN-1:0] IN_DISABLED_EVT,
  input wire logic [N_IN-1:0] IN_GO,
  input wire logic [N_IN-1:0] IN_STOP_REQ,
  input wire logic OUT0_SETUP_DONE_EVT,
  input wire logic OUT0_GO
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_setup_ack:
  assert property (TOKEN_VALID && TOKEN_PID == UEPC_TOK_SETUP && TOKEN_EP == 4'h0
    |=> HS_VALID && HS_CODE == UEPC_HS_ACK) else $error("setup not acked");
  a_go_before_evt:
  assert property (|IN_XFER_DONE_EVT |-> (IN_XFER_DONE_EVT & $past(IN_GO)) == '0)
    else $error("done event while go set");
  a_done_clears_go:
  assert property (|IN_XFER_DONE |=> (IN_GO & $past(IN_XFER_DONE)) == '0)
    else $error("go not cleared by done");
  a_stop_before_evt:
  assert property (|IN_DISABLED_EVT |-> (IN_DISABLED_EVT & $past(IN_GO | IN_STOP_REQ)) == '0)
    else $error("disable event while go or stop set");
  a_setup_evt_go:
  assert property (OUT0_SETUP_DONE_EVT |-> !$past(OUT0_GO)) else $error("setup event with go");
  a_in_nak_nodata:
  assert property (TOKEN_VALID && TOKEN_PID == UEPC_TOK_IN && GLOBAL_IN_NAK
    |=> !(HS_VALID && HS_CODE == UEPC_HS_DATA)) else $error("data sent under nak");
  a_b_single:
  assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("bvalid repeats");
  a_r_single:
  assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("rvalid repeats");
endmodule
`default_nettype wire

// *** tb/uepc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module uepc_host
  import uepc_pkg::*;
(
  input wire logic clk,
  input wire logic req,
  input wire uepc_tok_e req_pid,
  input wire logic [3:0] req_ep,
  input wire logic slow,
  input wire logic hs_valid,
  input wire uepc_hs_e hs_code,
  output logic tok_valid,
  output uepc_tok_e tok_pid,
  output logic [3:0] tok_ep,
  output logic [7:0] host_ack
);
  logic [3:0] last_ep;
  logic [7:0] ack_now;
  logic [7:0] ack_d;
  initial
  begin
    {tok_valid, tok_ep, last_ep, host_ack, ack_d} = '0;
    tok_pid = UEPC_TOK_OUT;
  end
  assign ack_now = (hs_valid && hs_code == UEPC_HS_DATA) ? 8'h01 << last_ep : 8'h00;
  always @(posedge clk)
  begin
    tok_valid <= req;
    // Idle lines churn so a stale token is never mistaken for a live one
    tok_pid <= req ? req_pid : uepc_tok_e'(~tok_pid);
    tok_ep <= req ? req_ep : ~tok_ep;
    if (req)
      last_ep <= req_ep;
    ack_d <= ack_now;
    host_ack <= slow ? ack_d : ack_now;
  end
endmodule
`default_nettype wire
